// >>> core/gpio_port.sv
// Eight-bit general-purpose port with address outputs on the low nibble and timer pin sharing.
// Assumes an AHB-Lite master on i_clk, same-clock standby and manual reset levels, asynchronous pins.
`timescale 1ns/1ps
module gpio_port
    import gpio_port_pkg::*;
(
    input  wire logic                  i_clk,
    input  wire logic                  i_resetn,
    input  wire logic                  i_hsel,
    input  wire logic [31:0]           i_haddr,
    input  wire logic [1:0]            i_htrans,
    input  wire logic                  i_hwrite,
    input  wire logic [2:0]            i_hsize,
    input  wire logic [31:0]           i_hwdata,
    input  wire logic                  i_hready,
    output logic                       o_hreadyout,
    output logic [31:0]                o_hrdata,
    output logic                       o_hresp,
    input  wire logic [2:0]            i_mode,
    input  wire logic                  i_manual_reset,
    input  wire logic                  i_hw_standby,
    input  wire logic                  i_sw_standby,
    input  wire logic [ADDR_PINS-1:0]  i_addr,
    input  wire logic [PORT_WIDTH-1:0] i_timer_out,
    input  wire logic [PORT_WIDTH-1:0] i_timer_oe,
    input  wire logic [PORT_WIDTH-1:0] i_pin_in,
    output logic [PORT_WIDTH-1:0]      o_pin_out,
    output logic [PORT_WIDTH-1:0]      o_pin_oe
);

    function automatic reg_sel_e decode(input logic [DEC_WIDTH-1:0] addr);
        reg_sel_e sel;
        sel = SEL_NONE;
        if (addr == ADDR_DIRECTION)
            sel = SEL_DIR;
        else if (addr == ADDR_LEVEL)
            sel = SEL_LEVEL;
        else if (addr == ADDR_LATCH)
            sel = SEL_LATCH;
        else if (addr == ADDR_CONTROL)
            sel = SEL_CTRL;
        return sel;
    endfunction

    function automatic logic is_addr_mode(input logic [2:0] mode);
        logic res;
        res = 1'b0;
        unique case (op_mode_e'(mode))
            MODE_4, MODE_5, MODE_6: res = 1'b1;
            default:                res = 1'b0;
        endcase
        return res;
    endfunction

    logic                  addr_ok;
    reg_sel_e              addr_sel;
    logic                  wr_pend_q;
    reg_sel_e              wsel_q;
    logic                  rd_pend_q;
    reg_sel_e              rd_sel_q;
    logic [PORT_WIDTH-1:0] dir_q;
    logic [PORT_WIDTH-1:0] dir_d;
    logic [PORT_WIDTH-1:0] latch_q;
    logic [PORT_WIDTH-1:0] latch_d;
    logic [7:0]            ctrl_q;
    logic [7:0]            ctrl_d;
    logic [PORT_WIDTH-1:0] pin_sync;
    logic [7:0]            rd_value;
    logic                  addr_mode;
    logic [PORT_WIDTH-1:0] addr_mask;
    logic [PORT_WIDTH-1:0] timer_drive;
    logic [PORT_WIDTH-1:0] drv_out;
    logic [PORT_WIDTH-1:0] drv_oe;
    logic [PORT_WIDTH-1:0] pin_out_d;
    logic [PORT_WIDTH-1:0] pin_oe_d;
    logic                  hold;

    assign addr_ok  = i_hsel && (i_htrans == HTRANS_NONSEQ) && i_hready;
    assign addr_sel = decode(i_haddr[DEC_WIDTH-1:0]);

    // Address phase capture; the slave never inserts wait states.
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            wr_pend_q <= 1'b0;
            wsel_q    <= SEL_NONE;
            rd_pend_q <= 1'b0;
            rd_sel_q  <= SEL_NONE;
        end
        else
        begin
            wr_pend_q <= addr_ok && i_hwrite;
            wsel_q    <= addr_sel;
            rd_pend_q <= addr_ok && !i_hwrite;
            rd_sel_q  <= addr_sel;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_hreadyout <= 1'b0;
            o_hresp     <= HRESP_OKAY;
        end
        else
        begin
            o_hreadyout <= 1'b1;
            o_hresp     <= HRESP_OKAY;
        end
    end

    // Register next values; a write of the level register falls through and changes nothing.
    always_comb
    begin
        dir_d   = dir_q;
        latch_d = latch_q;
        ctrl_d  = ctrl_q;
        if (i_hw_standby)
        begin
            dir_d   = DIR_RESET;
            latch_d = LATCH_RESET;
            ctrl_d  = CONTROL_RESET;
        end
        else if (wr_pend_q)
        begin
            unique case (wsel_q)
                SEL_DIR:   dir_d   = i_hwdata[7:0];
                SEL_LATCH: latch_d = i_hwdata[7:0];
                SEL_CTRL:  ctrl_d  = i_hwdata[7:0];
                SEL_LEVEL: latch_d = latch_q;
                SEL_NONE:  ctrl_d  = ctrl_q;
            endcase
        end
    end

    // Manual reset and software standby do not touch these registers.
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            dir_q <= DIR_RESET;
        else
            dir_q <= dir_d;
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            latch_q <= LATCH_RESET;
        else
            latch_q <= latch_d;
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            ctrl_q <= CONTROL_RESET;
        else
            ctrl_q <= ctrl_d;
    end

    port_sync u_sync
    (
        .i_clk    (i_clk),
        .i_resetn (i_resetn),
        .i_async  (i_pin_in),
        .o_level  (pin_sync)
    );

    // Latch, control and level reads see the next register values so a read right behind a write returns the new data.
    always_comb
    begin
        rd_value = 8'h00;
        unique case (addr_sel)
            SEL_DIR:   rd_value = DIR_READ_VALUE;
            SEL_LEVEL: rd_value = (dir_d & latch_d) | (~dir_d & pin_sync);
            SEL_LATCH: rd_value = latch_d;
            SEL_CTRL:  rd_value = ctrl_d;
            SEL_NONE:  rd_value = 8'h00;
        endcase
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
            o_hrdata <= HRDATA_RESET;
        else if (addr_ok && !i_hwrite)
            o_hrdata <= {24'h00_0000, rd_value};
        else
            o_hrdata <= HRDATA_RESET;
    end

    assign addr_mode   = is_addr_mode(i_mode);
    assign addr_mask   = addr_mode ? ADDR_PIN_MASK : 8'h00;
    assign hold        = ctrl_q[HOLD_BIT];
    // The timer is held in reset by a manual reset, so its pin claims are dropped then.
    assign timer_drive = i_timer_oe & {PORT_WIDTH{!i_manual_reset}};

    // One continuous assignment per bit keeps every bit of the drive vectors to a single driver.
    genvar g;
    generate
        for (g = 0; g < PORT_WIDTH; g++)
        begin : g_pin
            if (g < ADDR_PINS)
            begin : g_low
                assign drv_oe[g]  = dir_q[g] | (timer_drive[g] & !addr_mode);
                assign drv_out[g] = addr_mode ? i_addr[g] : (timer_drive[g] ? i_timer_out[g] : latch_q[g]);
            end
            else
            begin : g_high
                assign drv_oe[g]  = dir_q[g] | timer_drive[g];
                assign drv_out[g] = timer_drive[g] ? i_timer_out[g] : latch_q[g];
            end
        end
    endgenerate

    always_comb
    begin
        pin_oe_d  = drv_oe;
        pin_out_d = drv_out;
        if (i_hw_standby)
        begin
            pin_oe_d  = '0;
            pin_out_d = '0;
        end
        else if (i_sw_standby && hold)
        begin
            pin_oe_d  = (o_pin_oe & addr_mask) | (drv_oe & ~addr_mask);
            pin_out_d = (o_pin_out & addr_mask) | (drv_out & ~addr_mask);
        end
        else if (i_sw_standby)
        begin
            pin_oe_d = drv_oe & ~addr_mask;
        end
    end

    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            o_pin_oe  <= '0;
            o_pin_out <= '0;
        end
        else
        begin
            o_pin_oe  <= pin_oe_d;
            o_pin_out <= pin_out_d;
        end
    end

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    property p_dir_read;
        rd_pend_q && (rd_sel_q == SEL_DIR) |-> (o_hrdata[7:0] == DIR_READ_VALUE) && (o_hrdata[31:8] == 24'h00_0000);
    endproperty
    a_dir_read: assert property (p_dir_read) else $error("Direction read leaked data.");

    property p_hw_clear;
        i_hw_standby |=> (dir_q == DIR_RESET) && (latch_q == LATCH_RESET) && (o_pin_oe == '0);
    endproperty
    a_hw_clear: assert property (p_hw_clear) else $error("Hardware standby did not clear.");

    property p_manual_keep;
        i_manual_reset && !i_hw_standby && !wr_pend_q |=> $stable(dir_q);
    endproperty
    a_manual_keep: assert property (p_manual_keep) else $error("Direction lost on manual reset.");

    property p_sw_keep;
        i_sw_standby && !i_hw_standby && !wr_pend_q |=> $stable(latch_q);
    endproperty
    a_sw_keep: assert property (p_sw_keep) else $error("Latch lost in software standby.");

    property p_manual_pins;
        i_manual_reset && !i_hw_standby && !i_sw_standby && !addr_mode |=>
            (o_pin_oe == $past(dir_q)) && ((o_pin_out & o_pin_oe) == ($past(latch_q) & $past(dir_q)));
    endproperty
    a_manual_pins: assert property (p_manual_pins) else $error("Pins not set by port after manual reset.");

    property p_general;
        !addr_mode && !i_hw_standby && !i_sw_standby && (i_timer_oe == '0) |=>
            (o_pin_oe == $past(dir_q)) && ((o_pin_out & o_pin_oe) == ($past(latch_q) & $past(dir_q)));
    endproperty
    a_general: assert property (p_general) else $error("General port pin drive wrong.");

    property p_addr_low;
        addr_mode && !i_hw_standby && !i_sw_standby |=> (o_pin_oe[3:0] == $past(dir_q[3:0])) &&
            (((o_pin_out[3:0] ^ $past(i_addr)) & o_pin_oe[3:0]) == 4'h0);
    endproperty
    a_addr_low: assert property (p_addr_low) else $error("Address pins wrong.");

    property p_addr_high;
        addr_mode && !i_hw_standby && !i_sw_standby && (i_timer_oe[7:4] == 4'h0) |=>
            (o_pin_oe[7:4] == $past(dir_q[7:4])) &&
            ((o_pin_out[7:4] & o_pin_oe[7:4]) == ($past(latch_q[7:4]) & $past(dir_q[7:4])));
    endproperty
    a_addr_high: assert property (p_addr_high) else $error("Upper pins wrong in address mode.");

    property p_standby_float;
        i_sw_standby && !i_hw_standby && !hold && addr_mode |=> (o_pin_oe[3:0] == 4'h0);
    endproperty
    a_standby_float: assert property (p_standby_float) else $error("Address pins not floated.");

    property p_standby_hold;
        i_sw_standby && !i_hw_standby && hold && addr_mode |=> $stable(o_pin_oe[3:0]) && $stable(o_pin_out[3:0]);
    endproperty
    a_standby_hold: assert property (p_standby_hold) else $error("Address pins not held.");

    property p_latch_write;
        wr_pend_q && (wsel_q == SEL_LATCH) && !i_hw_standby |=> (latch_q == $past(i_hwdata[7:0]));
    endproperty
    a_latch_write: assert property (p_latch_write) else $error("Latch write lost.");

    property p_latch_read;
        rd_pend_q && (rd_sel_q == SEL_LATCH) |-> (o_hrdata == {24'h00_0000, latch_q});
    endproperty
    a_latch_read: assert property (p_latch_read) else $error("Latch read mismatch.");

    property p_level_read;
        rd_pend_q && (rd_sel_q == SEL_LEVEL) |-> (o_hrdata[7:0] == ((dir_q & latch_q) | (~dir_q & $past(pin_sync))));
    endproperty
    a_level_read: assert property (p_level_read) else $error("Pin level read mismatch.");

    property p_level_write;
        wr_pend_q && (wsel_q == SEL_LEVEL) && !i_hw_standby |=> $stable(latch_q) && $stable(dir_q);
    endproperty
    a_level_write: assert property (p_level_write) else $error("Pin level write had effect.");

    property p_unmapped;
        rd_pend_q && (rd_sel_q == SEL_NONE) |-> (o_hrdata == 32'h0000_0000) && o_hreadyout && (o_hresp == HRESP_OKAY);
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("Unmapped read not zero.");

    property p_sync;
        $stable(i_pin_in) [*6] |-> (pin_sync == i_pin_in);
    endproperty
    a_sync: assert property (p_sync) else $error("Pin synchroniser slow.");

    property p_cov_write_then_level;
        wr_pend_q && (wsel_q == SEL_LATCH) ##1 rd_pend_q && (rd_sel_q == SEL_LEVEL);
    endproperty
    c_write_then_level: cover property (p_cov_write_then_level);

    property p_cov_hold;
        i_sw_standby && hold && addr_mode && (o_pin_oe[3:0] != 4'h0);
    endproperty
    c_hold: cover property (p_cov_hold);

    property p_cov_addr;
        addr_mode && !i_sw_standby ##1 (o_pin_oe[3:0] == 4'hF);
    endproperty
    c_addr: cover property (p_cov_addr);

endmodule

// >>> core/port_sync.sv
// Three-stage synchroniser for the port pin levels with a two-stage agreement filter.
// Assumes the pins are asynchronous to i_clk; the output changes only when stages two and three agree.
`timescale 1ns/1ps
module port_sync
    import gpio_port_pkg::*;
(
    input  wire logic                  i_clk,
    input  wire logic                  i_resetn,
    input  wire logic [PORT_WIDTH-1:0] i_async,
    output logic      [PORT_WIDTH-1:0] o_level
);

    logic [PORT_WIDTH-1:0] meta_q;
    logic [PORT_WIDTH-1:0] stage2_q;
    logic [PORT_WIDTH-1:0] stage3_q;

    // The first stage feeds only the second stage.
    always_ff @(posedge i_clk or negedge i_resetn)
    begin
        if (!i_resetn)
        begin
            meta_q   <= '0;
            stage2_q <= '0;
            stage3_q <= '0;
        end
        else
        begin
            meta_q   <= i_async;
            stage2_q <= meta_q;
            stage3_q <= stage2_q;
        end
    end

    genvar g;
    generate
        for (g = 0; g < PORT_WIDTH; g++)
        begin : g_bit
            always_ff @(posedge i_clk or negedge i_resetn)
            begin
                if (!i_resetn)
                    o_level[g] <= 1'b0;
                else if (stage2_q[g] == stage3_q[g])
                    o_level[g] <= stage3_q[g];
            end
        end
    endgenerate

endmodule

// >>> shared/gpio_port_pkg.sv
// Package for the eight-bit port with address output: register map, reset values and decode types.
// Assumes a single system clock and an AHB-Lite register bus with 32-bit data.
package gpio_port_pkg;

    localparam int          PORT_WIDTH      = 8;
    localparam int          ADDR_PINS       = 4;
    localparam int          DEC_WIDTH       = 16;

    // Byte addresses, only the lower 16 bits of haddr take part in the match.
    localparam logic [15:0] ADDR_DIRECTION  = 16'hFEB0;
    localparam logic [15:0] ADDR_LEVEL      = 16'hFF50;
    localparam logic [15:0] ADDR_LATCH      = 16'hFF60;
    localparam logic [15:0] ADDR_CONTROL    = 16'hFF70;

    localparam logic [7:0]  DIR_RESET       = 8'h00;
    localparam logic [7:0]  LATCH_RESET     = 8'h00;
    localparam logic [7:0]  CONTROL_RESET   = 8'h00;
    // Value returned by a read of the write-only direction register; the stored bits never leak out.
    localparam logic [7:0]  DIR_READ_VALUE  = 8'hFF;
    localparam int          HOLD_BIT        = 0;
    localparam logic [7:0]  ADDR_PIN_MASK   = 8'h0F;

    localparam logic [1:0]  HTRANS_NONSEQ   = 2'b10;
    localparam logic        HRESP_OKAY      = 1'b0;
    localparam logic [31:0] HRDATA_RESET    = 32'h0000_0000;

    typedef enum logic [2:0] {
        SEL_NONE  = 3'b000,
        SEL_DIR   = 3'b001,
        SEL_LEVEL = 3'b010,
        SEL_LATCH = 3'b011,
        SEL_CTRL  = 3'b100
    } reg_sel_e;

    typedef enum logic [2:0] {
        MODE_0 = 3'b000,
        MODE_1 = 3'b001,
        MODE_2 = 3'b010,
        MODE_3 = 3'b011,
        MODE_4 = 3'b100,
        MODE_5 = 3'b101,
        MODE_6 = 3'b110,
        MODE_7 = 3'b111
    } op_mode_e;

endpackage

// >>> test/pin_partner.sv
// Model of the pads outside the port: the device drive, an outside driver and a floating line.
// Assumes the bench sets the outside driver's value and enable; the device wins where it drives.
`timescale 1ns/1ps
module pin_partner
    import gpio_port_pkg::*;
(
    input  wire logic                  i_clk,
    input  wire logic [PORT_WIDTH-1:0] i_pin_out,
    input  wire logic [PORT_WIDTH-1:0] i_pin_oe,
    input  wire logic [PORT_WIDTH-1:0] i_ext_val,
    input  wire logic [PORT_WIDTH-1:0] i_ext_en,
    output logic      [PORT_WIDTH-1:0] o_pin_level
);
    logic [PORT_WIDTH-1:0] last_q = '0;

    always_ff @(posedge i_clk)
    begin
        last_q <= o_pin_level;
    end

    // A pin that nobody drives floats; toggling it stops a simulator-chosen level from passing as data.
    always_comb
    begin
        for (int g = 0; g < PORT_WIDTH; g++)
        begin
            if (i_pin_oe[g])
                o_pin_level[g] = i_pin_out[g];
            else if (i_ext_en[g])
                o_pin_level[g] = i_ext_val[g];
            else
                o_pin_level[g] = ~last_q[g];
        end
    end
endmodule

// >>> test/tb_eight_bit_port_with_address_out.sv
// Self-checking bench for the eight-bit port: a table of mode cases, then register, standby and reset cases.
// Assumes pin_partner models the pads and one AHB-Lite master task issues single word transfers.
`timescale 1ns/1ps
`define CHK(nm, exp, got) \
    begin \
        n_compared++; \
        if ((got) !== (exp)) \
        begin \
            error_cnt++; \
            $display("wrong value %s exp %h got %h", nm, exp, got); \
        end \
    end
module tb_eight_bit_port_with_address_out;
    import gpio_port_pkg::*;

    typedef struct packed {
        logic [2:0] md;
        logic [7:0] dir;
        logic [7:0] lat;
        logic [3:0] ad;
        logic [7:0] ext;
        logic [7:0] oe;
        logic [7:0] out;
        logic [7:0] lvl;
    } row_s;

    logic        i_clk      = 1'b0;
    logic        i_resetn   = 1'b0;
    logic        hsel       = 1'b0;
    logic [31:0] haddr      = 32'h0000_0000;
    logic [1:0]  htrans     = 2'h0;
    logic        hwrite     = 1'b0;
    logic [2:0]  hsize      = 3'h0;
    logic [31:0] hwdata     = 32'h0000_0000;
    logic        hready_out;
    logic [31:0] hrdata;
    logic        hresp;
    logic [2:0]  mode       = 3'h1;
    logic        man_rst    = 1'b0;
    logic        hw_sby     = 1'b0;
    logic        sw_sby     = 1'b0;
    logic [3:0]  addr_bus   = 4'h0;
    logic [7:0]  tmr_out    = 8'h00;
    logic [7:0]  tmr_oe     = 8'h00;
    logic [7:0]  ext_val    = 8'h00;
    logic [7:0]  ext_en     = 8'hFF;
    logic [7:0]  pin_lvl;
    logic [7:0]  pin_out;
    logic [7:0]  pin_oe;
    int          error_cnt  = 0;
    int          n_compared = 0;
    row_s        rows [7]   = '{
        '{3'h1, 8'hA5, 8'h3C, 4'h0, 8'h0F, 8'hA5, 8'h24, 8'h2E},
        '{3'h2, 8'hFF, 8'h5A, 4'h0, 8'h00, 8'hFF, 8'h5A, 8'h5A},
        '{3'h3, 8'h00, 8'hFF, 4'h0, 8'hC3, 8'h00, 8'h00, 8'hC3},
        '{3'h7, 8'h0F, 8'h81, 4'h0, 8'hF0, 8'h0F, 8'h01, 8'hF1},
        '{3'h4, 8'hFF, 8'h96, 4'h9, 8'h00, 8'hFF, 8'h99, 8'h96},
        '{3'h5, 8'h3C, 8'hF0, 4'h5, 8'h81, 8'h3C, 8'h34, 8'hB1},
        '{3'h6, 8'hC3, 8'h0F, 4'hA, 8'h3C, 8'hC3, 8'h02, 8'h3F}
    };

    always #2 i_clk = ~i_clk;

    gpio_port i_dut (
        .i_clk(i_clk), .i_resetn(i_resetn), .i_hsel(hsel), .i_haddr(haddr), .i_htrans(htrans),
        .i_hwrite(hwrite), .i_hsize(hsize), .i_hwdata(hwdata), .i_hready(hready_out),
        .o_hreadyout(hready_out), .o_hrdata(hrdata), .o_hresp(hresp), .i_mode(mode),
        .i_manual_reset(man_rst), .i_hw_standby(hw_sby), .i_sw_standby(sw_sby), .i_addr(addr_bus),
        .i_timer_out(tmr_out), .i_timer_oe(tmr_oe), .i_pin_in(pin_lvl), .o_pin_out(pin_out),
        .o_pin_oe(pin_oe)
    );

    pin_partner i_pads (
        .i_clk(i_clk), .i_pin_out(pin_out), .i_pin_oe(pin_oe), .i_ext_val(ext_val),
        .i_ext_en(ext_en), .o_pin_level(pin_lvl)
    );

    task automatic tick(input int n);
        repeat (n) @(posedge i_clk);
    endtask

    // Called just after a rising edge; the address phase holds until hready is seen high.
    task automatic bus(input logic wr, input logic [15:0] a, input logic [7:0] wd, output logic [31:0] rdv);
        int n;
        hsel <= 1'b1;
        htrans <= HTRANS_NONSEQ;
        haddr <= {16'hA5A5, a};
        hwrite <= wr;
        hsize <= 3'h2;
        n = 0;
        do
        begin
            @(posedge i_clk);
            n++;
        end
        while (hready_out !== 1'b1 && n < 20);
        if (n >= 20)
            error_cnt++;
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {24'h00_0000, wd};
        n = 0;
        do
        begin
            @(posedge i_clk);
            n++;
        end
        while (hready_out !== 1'b1 && n < 20);
        rdv = hrdata;
        `CHK("hresp", HRESP_OKAY, hresp)
        if (n >= 20)
            error_cnt++;
    endtask

    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        logic [31:0] x;
        bus(1'b1, a, d, x);
    endtask

    task automatic rd_chk(input logic [15:0] a, input logic [7:0] e, input string nm);
        logic [31:0] x;
        bus(1'b0, a, 8'h00, x);
        `CHK(nm, {24'h00_0000, e}, x)
    endtask

    task automatic end_of_test();
        if (error_cnt == 0 && n_compared > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask

    initial
    begin
        tick(5);
        i_resetn <= 1'b1;
        tick(2);
        foreach (rows[k])
        begin
            mode <= rows[k].md;
            addr_bus <= rows[k].ad;
            ext_val <= rows[k].ext;
            wr(ADDR_DIRECTION, rows[k].dir);
            wr(ADDR_LATCH, rows[k].lat);
            tick(6);
            `CHK("pin_oe", rows[k].oe, pin_oe)
            `CHK("pin_out", rows[k].out, pin_out & pin_oe)
            rd_chk(ADDR_LEVEL, rows[k].lvl, "pin_level");
            rd_chk(ADDR_LATCH, rows[k].lat, "output_latch");
            rd_chk(ADDR_DIRECTION, DIR_READ_VALUE, "pin_direction");
        end
        wr(ADDR_LEVEL, 8'h00);
        rd_chk(ADDR_LEVEL, 8'h3F, "pin_level after write");
        rd_chk(16'h1234, 8'h00, "unmapped");
        mode <= 3'h1;
        wr(ADDR_DIRECTION, 8'h00);
        wr(ADDR_LATCH, 8'h5A);
        tick(3);
        `CHK("pin_oe input", 8'h00, pin_oe)
        wr(ADDR_DIRECTION, 8'hFF);
        tick(3);
        `CHK("pin_out late", 8'h5A, pin_out)
        mode <= 3'h4;
        addr_bus <= 4'h3;
        wr(ADDR_DIRECTION, 8'h0F);
        wr(ADDR_LATCH, 8'hA0);
        wr(ADDR_CONTROL, 8'h01);
        tick(3);
        sw_sby <= 1'b1;
        tick(2);
        addr_bus <= 4'hC;
        tick(3);
        `CHK("held address", 8'h03, pin_out & 8'h0F)
        `CHK("held enable", 8'h0F, pin_oe)
        wr(ADDR_CONTROL, 8'h00);
        tick(3);
        `CHK("floated address", 8'h00, pin_oe & 8'h0F)
        sw_sby <= 1'b0;
        rd_chk(ADDR_LATCH, 8'hA0, "latch after standby");
        mode <= 3'h1;
        wr(ADDR_DIRECTION, 8'h80);
        tmr_oe <= 8'h80;
        tmr_out <= 8'h00;
        tick(3);
        `CHK("timer drive", 8'h00, pin_out & 8'h80)
        man_rst <= 1'b1;
        tick(3);
        `CHK("manual reset out", 8'h80, pin_out & 8'h80)
        `CHK("manual reset oe", 8'h80, pin_oe)
        rd_chk(ADDR_LATCH, 8'hA0, "latch after manual reset");
        man_rst <= 1'b0;
        tmr_oe <= 8'h00;
        hw_sby <= 1'b1;
        tick(3);
        `CHK("hw standby oe", 8'h00, pin_oe)
        hw_sby <= 1'b0;
        tick(2);
        rd_chk(ADDR_LATCH, 8'h00, "latch after hw standby");
        `CHK("dir after hw standby", 8'h00, pin_oe)
        wr(ADDR_LATCH, 8'h77);
        wr(ADDR_DIRECTION, 8'hFF);
        tick(3);
        i_resetn <= 1'b0;
        tick(2);
        `CHK("hready in reset", 1'b0, hready_out)
        `CHK("oe in reset", 8'h00, pin_oe)
        i_resetn <= 1'b1;
        tick(3);
        rd_chk(ADDR_LATCH, LATCH_RESET, "latch after reset");
        `CHK("dir after reset", DIR_RESET, pin_oe)
        end_of_test();
    end

    // Whole run needs well under a thousand cycles; this only catches a hung handshake.
    initial
    begin
        #20000;
        error_cnt++;
        end_of_test();
    end
endmodule
